// ### dv/psk_seed_model.sv
// datapath stand-in that answers a seed load request after a set delay
`timescale 1ns/100ps
`default_nettype none
module psk_seed_model #(
    parameter int DELAY = 1
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // seed handshake
    input  wire logic                      load,
    input  wire logic [psk_pkg::KEY_W-1:0] seed,
    output var  logic                      done
);
    logic [psk_pkg::KEY_W-1:0] key_reg;
    int                        cnt_reg;
    // capture the seed on the request, then pulse done after the delay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                cnt_reg <= DELAY;
                key_reg <= seed;
            end else if (cnt_reg != 0) begin
                cnt_reg <= cnt_reg - 1;
                done    <= (cnt_reg == 1);
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/test_psk_stats_keys.sv
// self-checking bench for the statistics counters and seed registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_psk_stats_keys;
    logic                       SYS_CLK, RESETN, REG_WR, REG_RD, REG_RVALID;
    logic [psk_pkg::ADDR_W-1:0] REG_ADDR;
    logic [psk_pkg::DATA_W-1:0] REG_WDATA, REG_RDATA;
    logic LINK_OK, FALSE_CARRIER, RX_DV, RX_ER, COLLISION, COMPAT_MODE;
    logic [psk_pkg::KEY_W-1:0]  TX_SEED, RX_SEED;
    logic TX_SEED_LOAD, TX_SEED_DONE, TX_SCRAMBLE_BYPASS;
    logic RX_SEED_LOAD, RX_SEED_DONE, RX_DESCRAMBLE_BYPASS, F_LL, F_FC, F_RE;
    int   n_fail = 0;
    int   n_tests = 0;
    psk_stats_keys dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .LINK_OK(LINK_OK), .FALSE_CARRIER(FALSE_CARRIER),
        .RX_DV(RX_DV), .RX_ER(RX_ER), .COLLISION(COLLISION), .COMPAT_MODE(COMPAT_MODE),
        .TX_SEED_INIT(11'h2A5), .RX_SEED_INIT(11'h000), .TX_SEED(TX_SEED),
        .TX_SEED_LOAD(TX_SEED_LOAD), .TX_SEED_DONE(TX_SEED_DONE),
        .TX_SCRAMBLE_BYPASS(TX_SCRAMBLE_BYPASS), .RX_SEED(RX_SEED),
        .RX_SEED_LOAD(RX_SEED_LOAD), .RX_SEED_DONE(RX_SEED_DONE),
        .RX_DESCRAMBLE_BYPASS(RX_DESCRAMBLE_BYPASS), .LINK_LOSS_COUNT_MSB_FLAG(F_LL),
        .FALSE_CARRIER_COUNT_MSB_FLAG(F_FC), .RX_ERROR_COUNT_MSB_FLAG(F_RE));
    // slow scrambler side, prompt descrambler side
    psk_seed_model #(.DELAY(20)) m_tx (.clk(SYS_CLK), .rst_n(RESETN),
        .load(TX_SEED_LOAD), .seed(TX_SEED), .done(TX_SEED_DONE));
    psk_seed_model #(.DELAY(1)) m_rx (.clk(SYS_CLK), .rst_n(RESETN),
        .load(RX_SEED_LOAD), .seed(RX_SEED), .done(RX_SEED_DONE));
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge SYS_CLK); #1;
        REG_WR = 1'b1; REG_ADDR = a; REG_WDATA = d;
        @(posedge SYS_CLK); #1;
        REG_WR = 1'b0;
    endtask
    // read one word; drop the link in the same cycle when asked
    task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic drop);
        @(posedge SYS_CLK); #1;
        REG_RD = 1'b1; REG_ADDR = a;
        if (drop) LINK_OK = 1'b0;
        @(posedge SYS_CLK); #1;
        REG_RD = 1'b0;
        `CHK("rvalid", 1'b1, REG_RVALID)
        `CHK("rdata", e, REG_RDATA)
    endtask
    task automatic tick(input int n);
        repeat (n) begin @(posedge SYS_CLK); #1; end
    endtask
    task automatic pkt(input logic er, input logic col);
        tick(1); RX_DV = 1'b1;
        tick(1); RX_ER = er; COLLISION = col;
        tick(1); RX_DV = 1'b0; RX_ER = 1'b0; COLLISION = 1'b0;
    endtask
    task automatic wait_done(input logic rx);
        for (int i = 0; i < 40; i++) begin
            if ((rx ? RX_SEED_DONE : TX_SEED_DONE) === 1'b1) break;
            tick(1);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // clock source
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    // watchdog
    initial begin
        #50000;
        n_fail++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        RESETN = 1'b0; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 5'h00;
        REG_WDATA = 16'h0000; LINK_OK = 1'b0; FALSE_CARRIER = 1'b0;
        RX_DV = 1'b0; RX_ER = 1'b0; COLLISION = 1'b0; COMPAT_MODE = 1'b0;
        tick(16);
        RESETN = 1'b1;
        rd(5'h12, 16'h0000, 1'b0);
        rd(5'h13, 16'h0000, 1'b0);
        rd(5'h15, 16'h0000, 1'b0);
        rd(5'h14, 16'h02A5, 1'b0);
        rd(5'h16, 16'h0000, 1'b0);
        `CHK("rx_bypass", 1'b1, RX_DESCRAMBLE_BYPASS)
        `CHK("tx_bypass", 1'b0, TX_SCRAMBLE_BYPASS)
        rd(5'h10, 16'h0000, 1'b0);
        // three link drops, then one drop colliding with the clearing read
        repeat (3) begin tick(1); LINK_OK = 1'b1; tick(1); LINK_OK = 1'b0; end
        tick(1); LINK_OK = 1'b1;
        rd(5'h12, 16'h0003, 1'b1);
        rd(5'h12, 16'h0001, 1'b0);
        rd(5'h12, 16'h0000, 1'b0);
        `CHK("ll_flag", 1'b0, F_LL)
        // one long false-carrier event steps once
        tick(1); FALSE_CARRIER = 1'b1; tick(5); FALSE_CARRIER = 1'b0;
        tick(2); FALSE_CARRIER = 1'b1; tick(1); FALSE_CARRIER = 1'b0;
        rd(5'h13, 16'h0002, 1'b0);
        rd(5'h13, 16'h0000, 1'b0);
        wr(5'h13, 16'h1234);
        rd(5'h13, 16'h0000, 1'b0);
        // only non-collision errored packets count
        pkt(1'b1, 1'b1); pkt(1'b1, 1'b0); pkt(1'b0, 1'b0); pkt(1'b1, 1'b0);
        rd(5'h15, 16'h0002, 1'b0);
        rd(5'h15, 16'h0000, 1'b0);
        `CHK("fc_flag", 1'b0, F_FC)
        `CHK("re_flag", 1'b0, F_RE)
        // scrambler seed load with slow datapath
        wr(5'h14, 16'h8123);
        `CHK("tx_load", 1'b1, TX_SEED_LOAD)
        `CHK("tx_seed", 11'h123, TX_SEED)
        rd(5'h14, 16'h8123, 1'b0);
        wait_done(1'b0);
        rd(5'h14, 16'h0123, 1'b0);
        `CHK("tx_loaded", 11'h123, m_tx.key_reg)
        wr(5'h14, 16'h8000);
        tick(1);
        `CHK("tx_bypass", 1'b1, TX_SCRAMBLE_BYPASS)
        wait_done(1'b0);
        // descrambler seed load with prompt datapath
        wr(5'h16, 16'h82BC);
        `CHK("rx_load", 1'b1, RX_SEED_LOAD)
        wait_done(1'b1);
        rd(5'h16, 16'h02BC, 1'b0);
        `CHK("rx_seed", 11'h2BC, RX_SEED)
        `CHK("rx_loaded", 11'h2BC, m_rx.key_reg)
        `CHK("rx_bypass", 1'b0, RX_DESCRAMBLE_BYPASS)
        // compatibility mode keeps stored keys
        COMPAT_MODE = 1'b1;
        wr(5'h16, 16'h0555);
        wr(5'h14, 16'h0555);
        rd(5'h16, 16'h02BC, 1'b0);
        rd(5'h14, 16'h0000, 1'b0);
        COMPAT_MODE = 1'b0;
        wr(5'h14, 16'h0555);
        `CHK("tx_noload", 1'b0, TX_SEED_LOAD)
        rd(5'h14, 16'h0555, 1'b0);
        report_and_stop();
    end
endmodule
`undef CHK
`default_nettype wire

// ### src/psk_event_counter.sv
// 16-bit clear-on-read event counter, wrapping or saturating
`timescale 1ns/100ps
`default_nettype none
module psk_event_counter #(
    parameter bit SATURATE = 1'b0
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // control
    input  wire logic                      inc,
    input  wire logic                      clr,
    // state
    output var  logic [psk_pkg::CNT_W-1:0] count,
    output var  logic                      msb_flag
);

    logic [psk_pkg::CNT_W-1:0] count_reg;
    logic [psk_pkg::CNT_W-1:0] count_next;
    logic                      flag_reg;

    // next count: a read clear never swallows a coincident event
    always_comb begin
        count_next = count_reg;
        if (clr) begin
            count_next = inc ? psk_pkg::CNT_ONE : psk_pkg::CNT_ZERO;
        end else if (inc) begin
            if (SATURATE && (count_reg == psk_pkg::CNT_MAX)) begin
                count_next = psk_pkg::CNT_MAX;
            end else begin
                count_next = count_reg + psk_pkg::CNT_ONE;
            end
        end
    end

    // registers; the flag tracks the count msb
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= psk_pkg::CNT_ZERO;
            flag_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            flag_reg  <= count_next[psk_pkg::CNT_MSB];
        end
    end

    assign count    = count_reg;
    assign msb_flag = flag_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    clear_wins_a: assert property (clr && inc |=> count_reg == psk_pkg::CNT_ONE)
        else $error("event lost on clear");
    cnt_limit_a: assert property (inc && !clr && count_reg == psk_pkg::CNT_MAX
        |=> count_reg == (SATURATE ? psk_pkg::CNT_MAX : psk_pkg::CNT_ZERO))
        else $error("counter limit behaviour wrong");
    cnt_clear_a: assert property (clr && !inc |=> count_reg == psk_pkg::CNT_ZERO)
        else $error("counter not cleared by read");

endmodule
`default_nettype wire

// ### src/psk_pkg.sv
// shared constants, types and decode helpers for the phy statistics and seed block
package psk_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned KEY_W  = 11;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_LINK_LOSS = 5'h12;
    localparam logic [ADDR_W-1:0] OFS_FALSE_CAR = 5'h13;
    localparam logic [ADDR_W-1:0] OFS_TX_SEED   = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_RX_ERR    = 5'h15;
    localparam logic [ADDR_W-1:0] OFS_RX_SEED   = 5'h16;

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int unsigned LOAD_BIT = 15;
    localparam int unsigned CNT_MSB  = 15;
    localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
    localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF;
    localparam logic [KEY_W-1:0]  KEY_ZERO = 11'h000;
    localparam logic [3:0]        RSVD_ZERO = 4'h0;
    localparam logic [DATA_W-1:0] RD_ZERO  = 16'h0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_REQ  = 2'b01,
        LD_WAIT = 2'b10
    } psk_load_state_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } psk_reg_req_t;

    typedef struct packed {
        logic [KEY_W-1:0] key;
        logic             load;
        logic             bypass;
        logic             pending;
    } psk_seed_t;

    // true when the request strobe hits the given offset
    function automatic logic psk_wr_hit(psk_reg_req_t r, logic [ADDR_W-1:0] ofs);
        psk_wr_hit = r.wr && (r.addr == ofs);
    endfunction

    function automatic logic psk_rd_hit(psk_reg_req_t r, logic [ADDR_W-1:0] ofs);
        psk_rd_hit = r.rd && (r.addr == ofs);
    endfunction

endpackage

// ### src/psk_seed_reg.sv
// scrambler or descrambler seed register with self-clearing load bit
`timescale 1ns/100ps
`default_nettype none
module psk_seed_reg #(
    parameter logic [psk_pkg::ADDR_W-1:0] OFS = psk_pkg::OFS_TX_SEED
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // register access
    input  wire psk_pkg::psk_reg_req_t     req,
    input  wire logic                      compat,
    input  wire logic [psk_pkg::KEY_W-1:0] init_key,
    // datapath handshake
    input  wire logic                      load_done,
    output var  psk_pkg::psk_seed_t        seed
);

    psk_pkg::psk_load_state_t  state_reg;
    psk_pkg::psk_load_state_t  state_next;
    logic [psk_pkg::KEY_W-1:0] key_reg;
    logic [psk_pkg::KEY_W-1:0] key_next;
    logic                      load_reg;
    logic                      bypass_reg;
    logic                      wr_hit;
    logic                      set_load;

    assign wr_hit   = psk_pkg::psk_wr_hit(req, OFS);
    assign set_load = wr_hit && req.wdata[psk_pkg::LOAD_BIT]; // writing zero does nothing

    // key field and load sequence
    always_comb begin
        key_next   = key_reg;
        state_next = state_reg;
        if (wr_hit && !compat) begin
            key_next = req.wdata[psk_pkg::KEY_W-1:0];
        end
        case (state_reg)
            psk_pkg::LD_IDLE: begin
                if (set_load) begin
                    state_next = psk_pkg::LD_REQ;
                end
            end
            psk_pkg::LD_REQ: begin
                state_next = set_load ? psk_pkg::LD_REQ : psk_pkg::LD_WAIT;
            end
            psk_pkg::LD_WAIT: begin
                if (set_load) begin
                    state_next = psk_pkg::LD_REQ;
                end else if (load_done) begin
                    state_next = psk_pkg::LD_IDLE;
                end
            end
            default: begin
                state_next = psk_pkg::LD_IDLE;
            end
        endcase
    end

    // registers; the key is taken from the strap while reset is held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg  <= psk_pkg::LD_IDLE;
            key_reg    <= init_key;
            load_reg   <= 1'b0;
            bypass_reg <= (init_key == psk_pkg::KEY_ZERO);
        end else begin
            state_reg  <= state_next;
            key_reg    <= key_next;
            load_reg   <= (state_next == psk_pkg::LD_REQ);
            bypass_reg <= (key_next == psk_pkg::KEY_ZERO);
        end
    end

    assign seed.key     = key_reg;
    assign seed.load    = load_reg;
    assign seed.bypass  = bypass_reg;
    assign seed.pending = (state_reg != psk_pkg::LD_IDLE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence load_issue;
        set_load ##1 load_reg;
    endsequence

    load_start_a: assert property (set_load |-> load_issue)
        else $error("load pulse not issued");
    self_clear_a: assert property (state_reg == psk_pkg::LD_WAIT && load_done && !set_load
        |=> !seed.pending)
        else $error("load bit did not self clear");
    compat_hold_a: assert property (compat && wr_hit |=> key_reg == $past(key_reg))
        else $error("key written in compatibility mode");
    key_bypass_a: assert property (bypass_reg == (key_reg == psk_pkg::KEY_ZERO))
        else $error("bypass disagrees with key");

endmodule
`default_nettype wire

// ### src/psk_stats_keys.sv
// top of the phy statistics counters and scrambler seed registers
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - link-loss counter counts each link-ok loss, clears on read, wraps to zero
// - false-carrier counter counts receptions starting with a malformed delimiter
// - false-carrier counter steps once per event, at the event's end
// - false-carrier counter clears on read and sticks at all ones
// - receive-error counter counts non-collision errored packets, clears on read, wraps
// - setting scrambler load bit loads scrambler seed; bit clears itself when done
// - scrambler key is 11 bits read/write; zero key bypasses transmit scrambling
// - setting descrambler load bit loads descrambler seed; bit clears itself when done
// - descrambler key is 11 bits read/write; zero key bypasses receive descrambling
// - key register bits 14 to 11 read zero; software writes them zero
// - compatibility mode makes key field writes ignored, keeping stored keys
// - read-only flags follow the msb of each of the three counters
module psk_stats_keys (
    // clock and reset
    input  wire logic                       SYS_CLK,
    input  wire logic                       RESETN,
    // register access port
    input  wire logic [psk_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic                       REG_WR,
    input  wire logic                       REG_RD,
    input  wire logic [psk_pkg::DATA_W-1:0] REG_WDATA,
    output var  logic [psk_pkg::DATA_W-1:0] REG_RDATA,
    output var  logic                       REG_RVALID,
    // event sources
    input  wire logic                       LINK_OK,
    input  wire logic                       FALSE_CARRIER,
    input  wire logic                       RX_DV,
    input  wire logic                       RX_ER,
    input  wire logic                       COLLISION,
    // configuration
    input  wire logic                       COMPAT_MODE,
    input  wire logic [psk_pkg::KEY_W-1:0]  TX_SEED_INIT,
    input  wire logic [psk_pkg::KEY_W-1:0]  RX_SEED_INIT,
    // scrambler side
    output var  logic [psk_pkg::KEY_W-1:0]  TX_SEED,
    output var  logic                       TX_SEED_LOAD,
    input  wire logic                       TX_SEED_DONE,
    output var  logic                       TX_SCRAMBLE_BYPASS,
    // descrambler side
    output var  logic [psk_pkg::KEY_W-1:0]  RX_SEED,
    output var  logic                       RX_SEED_LOAD,
    input  wire logic                       RX_SEED_DONE,
    output var  logic                       RX_DESCRAMBLE_BYPASS,
    // counter msb flags
    output var  logic                       LINK_LOSS_COUNT_MSB_FLAG,
    output var  logic                       FALSE_CARRIER_COUNT_MSB_FLAG,
    output var  logic                       RX_ERROR_COUNT_MSB_FLAG
);

    // ----------------------------------------------------------------
    // request bundle
    // ----------------------------------------------------------------
    psk_pkg::psk_reg_req_t req;

    always_comb begin
        req.wr    = REG_WR;
        req.rd    = REG_RD;
        req.addr  = REG_ADDR;
        req.wdata = REG_WDATA;
    end

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    logic link_ok_reg;
    logic link_ok_next;
    logic fc_reg;
    logic fc_next;
    logic rx_dv_reg;
    logic rx_dv_next;
    logic err_seen_reg;
    logic err_seen_next;
    logic link_inc;
    logic fc_inc;
    logic rx_err_inc;
    logic rx_err_now;

    // error in a packet counts only when no collision accompanies it
    assign rx_err_now = RX_DV && RX_ER && !COLLISION;
    // loss of link ok, detected on its falling edge
    assign link_inc   = link_ok_reg && !LINK_OK;
    // false carrier counted as its indication ends, so once per event
    assign fc_inc     = fc_reg && !FALSE_CARRIER;
    // errored packet counted once, when its data valid ends
    assign rx_err_inc = rx_dv_reg && !RX_DV && err_seen_reg;

    // next values of the edge and packet trackers
    always_comb begin
        link_ok_next  = LINK_OK;
        fc_next       = FALSE_CARRIER;
        rx_dv_next    = RX_DV;
        err_seen_next = err_seen_reg;
        if (!RX_DV) begin
            err_seen_next = 1'b0;
        end else if (rx_err_now) begin
            err_seen_next = 1'b1;
        end
    end

    // tracker registers
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            link_ok_reg  <= 1'b0;
            fc_reg       <= 1'b0;
            rx_dv_reg    <= 1'b0;
            err_seen_reg <= 1'b0;
        end else begin
            link_ok_reg  <= link_ok_next;
            fc_reg       <= fc_next;
            rx_dv_reg    <= rx_dv_next;
            err_seen_reg <= err_seen_next;
        end
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    logic [psk_pkg::CNT_W-1:0] link_cnt;
    logic [psk_pkg::CNT_W-1:0] fc_cnt;
    logic [psk_pkg::CNT_W-1:0] err_cnt;
    logic                      link_flag;
    logic                      fc_flag;
    logic                      err_flag;
    logic                      rd_link;
    logic                      rd_fc;
    logic                      rd_err;

    // a read of a counter clears it
    assign rd_link = psk_pkg::psk_rd_hit(req, psk_pkg::OFS_LINK_LOSS);
    assign rd_fc   = psk_pkg::psk_rd_hit(req, psk_pkg::OFS_FALSE_CAR);
    assign rd_err  = psk_pkg::psk_rd_hit(req, psk_pkg::OFS_RX_ERR);

    psk_event_counter #(.SATURATE(1'b0)) u_link_cnt (
        .clk      (SYS_CLK),
        .rst_n    (RESETN),
        .inc      (link_inc),
        .clr      (rd_link),
        .count    (link_cnt),
        .msb_flag (link_flag)
    );

    psk_event_counter #(.SATURATE(1'b1)) u_fc_cnt (
        .clk      (SYS_CLK),
        .rst_n    (RESETN),
        .inc      (fc_inc),
        .clr      (rd_fc),
        .count    (fc_cnt),
        .msb_flag (fc_flag)
    );

    psk_event_counter #(.SATURATE(1'b0)) u_err_cnt (
        .clk      (SYS_CLK),
        .rst_n    (RESETN),
        .inc      (rx_err_inc),
        .clr      (rd_err),
        .count    (err_cnt),
        .msb_flag (err_flag)
    );

    // ----------------------------------------------------------------
    // seed registers
    // ----------------------------------------------------------------
    psk_pkg::psk_seed_t tx_seed;
    psk_pkg::psk_seed_t rx_seed;

    psk_seed_reg #(.OFS(psk_pkg::OFS_TX_SEED)) u_tx_seed (
        .clk       (SYS_CLK),
        .rst_n     (RESETN),
        .req       (req),
        .compat    (COMPAT_MODE),
        .init_key  (TX_SEED_INIT),
        .load_done (TX_SEED_DONE),
        .seed      (tx_seed)
    );

    psk_seed_reg #(.OFS(psk_pkg::OFS_RX_SEED)) u_rx_seed (
        .clk       (SYS_CLK),
        .rst_n     (RESETN),
        .req       (req),
        .compat    (COMPAT_MODE),
        .init_key  (RX_SEED_INIT),
        .load_done (RX_SEED_DONE),
        .seed      (rx_seed)
    );

    assign TX_SEED                      = tx_seed.key;
    assign TX_SEED_LOAD                 = tx_seed.load;
    assign TX_SCRAMBLE_BYPASS           = tx_seed.bypass;
    assign RX_SEED                      = rx_seed.key;
    assign RX_SEED_LOAD                 = rx_seed.load;
    assign RX_DESCRAMBLE_BYPASS         = rx_seed.bypass;
    assign LINK_LOSS_COUNT_MSB_FLAG     = link_flag;
    assign FALSE_CARRIER_COUNT_MSB_FLAG = fc_flag;
    assign RX_ERROR_COUNT_MSB_FLAG      = err_flag;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [psk_pkg::DATA_W-1:0] rdata_reg;
    logic [psk_pkg::DATA_W-1:0] rdata_next;
    logic                       rvalid_reg;

    // read mux; the count is sampled before its clear takes effect
    always_comb begin
        rdata_next = rdata_reg;
        if (REG_RD) begin
            if (REG_ADDR == psk_pkg::OFS_LINK_LOSS) begin
                rdata_next = link_cnt;
            end else if (REG_ADDR == psk_pkg::OFS_FALSE_CAR) begin
                rdata_next = fc_cnt;
            end else if (REG_ADDR == psk_pkg::OFS_TX_SEED) begin
                rdata_next = {tx_seed.pending, psk_pkg::RSVD_ZERO, tx_seed.key};
            end else if (REG_ADDR == psk_pkg::OFS_RX_ERR) begin
                rdata_next = err_cnt;
            end else if (REG_ADDR == psk_pkg::OFS_RX_SEED) begin
                rdata_next = {rx_seed.pending, psk_pkg::RSVD_ZERO, rx_seed.key};
            end else begin
                rdata_next = psk_pkg::RD_ZERO;
            end
        end
    end

    // read data registers
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            rdata_reg  <= psk_pkg::RD_ZERO;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= REG_RD;
        end
    end

    assign REG_RDATA  = rdata_reg;
    assign REG_RVALID = rvalid_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // false carrier held over two cycles with no read as it starts
    sequence fc_active;
        FALSE_CARRIER && !rd_fc ##1 FALSE_CARRIER;
    endsequence

    // false carrier steps once per event, at its end
    fc_once_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        fc_active |-> fc_cnt == $past(fc_cnt))
        else $error("false carrier counted mid event");
    fc_end_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        $fell(FALSE_CARRIER) && !rd_fc && fc_cnt != psk_pkg::CNT_MAX
        |=> fc_cnt == $past(fc_cnt) + psk_pkg::CNT_ONE)
        else $error("false carrier end not counted");

    // link loss adds one, wrapping to zero past the top
    link_inc_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !rd_link ##1 $fell(LINK_OK) && !rd_link
        |=> link_cnt == $past(link_cnt, 2) + psk_pkg::CNT_ONE)
        else $error("link loss not counted");

    // a packet that ends just after an error cycle with no collision
    sequence err_pkt_end;
        RX_DV && RX_ER && !COLLISION ##1 !RX_DV && !rd_err;
    endsequence

    rx_err_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        RX_DV && RX_ER && COLLISION && !err_seen_reg ##1 !RX_DV && !rd_err
        |=> err_cnt == $past(err_cnt))
        else $error("collision error counted");
    rx_err_cnt_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        err_pkt_end |=> err_cnt == $past(err_cnt) + psk_pkg::CNT_ONE)
        else $error("errored packet not counted");

    // a read returns the count held before its own clear
    rd_link_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        rd_link |=> REG_RDATA == $past(link_cnt))
        else $error("link count lost on read");
    rd_fc_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        rd_fc |=> REG_RDATA == $past(fc_cnt))
        else $error("false carrier count lost on read");
    rd_err_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        rd_err |=> REG_RDATA == $past(err_cnt))
        else $error("receive error count lost on read");

    // flags follow the counter msb; reserved key bits read zero
    msb_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        LINK_LOSS_COUNT_MSB_FLAG == link_cnt[psk_pkg::CNT_MSB]
        && FALSE_CARRIER_COUNT_MSB_FLAG == fc_cnt[psk_pkg::CNT_MSB]
        && RX_ERROR_COUNT_MSB_FLAG == err_cnt[psk_pkg::CNT_MSB])
        else $error("msb flag disagrees with counter");
    rsvd_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        REG_RD && (REG_ADDR == psk_pkg::OFS_TX_SEED || REG_ADDR == psk_pkg::OFS_RX_SEED)
        |=> REG_RDATA[14:11] == psk_pkg::RSVD_ZERO)
        else $error("reserved key bits not zero");

    // reset clears counters and pending loads
    reset_zero_a: assert property (@(posedge SYS_CLK) disable iff (1'b0)
        !RESETN |=> link_cnt == psk_pkg::CNT_ZERO && fc_cnt == psk_pkg::CNT_ZERO
        && err_cnt == psk_pkg::CNT_ZERO && !tx_seed.pending && !rx_seed.pending)
        else $error("state not cleared by reset");

endmodule
`default_nettype wire
